// >>> design/netfail_params.svh
// constants for the process data watchdog and link-failure block
`ifndef NETFAIL_PARAMS_SVH
`define NETFAIL_PARAMS_SVH

// ==================================================
// timing
`define SYS_CLK_HZ        25000000
`define MS_PERIOD_US      1000
`define MS_CYCLES         ((`SYS_CLK_HZ / 1000000) * `MS_PERIOD_US)

// ==================================================
// register numbers
`define OFS_CONN_TIMEOUT  16'h0500
`define OFS_WD_TIMEOUT    16'h07d0
`define OFS_FAULT_MODE    16'h07d2
`define OFS_FAIL_REASON   16'h07d4
`define OFS_COMMAND       16'h07d6
`define OFS_STATUS        16'h1f3c
`define OFS_DIAG_STATUS   16'h1f3d
`define OFS_DIAG_PARAM    16'h1f3e
`define OFS_INPUT_IMAGE   16'h1f40
`define OFS_OUTPUT_IMAGE  16'h2328

// ==================================================
// reset values and limits
`define RST_TIMEOUT       16'h0000
`define RST_FAULT_MODE    16'h0000
`define RST_OUTPUT_IMAGE  16'h0000
`define RST_REASON        16'h0000
`define TIMEOUT_MIN_MS    16'h00c8
`define TIMEOUT_MAX_MS    16'hfde8

// ==================================================
// field positions and codes
`define CMD_SET_FAIL_BIT  4
`define CMD_ACK_BIT       5
`define STAT_ERROR_BIT    0
`define STAT_FAIL_BIT     1
`define DIAG_SHORT_BIT    0
`define MODE_ALL_LOW      16'h0000
`define MODE_ALL_HIGH     16'h0001
`define MODE_HOLD_LAST    16'h0002
`define REASON_USER       16'h0009
`define REASON_WATCHDOG   16'h000c
`define REASON_CONN       16'h000d
`define EXC_NONE          8'h00
`define EXC_ILLEGAL_FUNC  8'h01
`define EXC_ILLEGAL_ADDR  8'h02
`define EXC_ILLEGAL_VALUE 8'h03

// ==================================================
// function code masks, bit n set means code n; FC_READ_WRITE is a single code, not a mask
`define FC_SUPPORTED      32'h0081807e
`define FC_WRITING        32'h00818060
`define FC_SPECIAL_RW     32'h00810058
`define FC_READ_ONLY_REG  32'h00800018
`define FC_COMMAND        32'h00810040
`define FC_INPUT_IMAGE    32'h0080001e
`define FC_OUTPUT_IMAGE   32'h0081807e
`define FC_READ_WRITE     5'h17

`endif

// >>> design/netfail_pkg.sv
// types shared by the process data watchdog block
package netfail_pkg;

    // ==================================================
    // one register access of a client transaction
    typedef struct packed {
        logic        valid;
        logic [4:0]  func;
        logic        write;
        logic [2:0]  conn;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] wmask;
    } req_type;

    // answer to one access
    typedef struct packed {
        logic        valid;
        logic [7:0]  exception;
        logic [15:0] rdata;
    } resp_type;

    typedef enum logic {
        LINK_RUN  = 1'b0,
        LINK_FAIL = 1'b1
    } link_state_type;

endpackage : netfail_pkg

// >>> design/process_data_watchdog_netfail.sv
// process data watchdog, connection monitor and link-failure output control
`timescale 1ns/100ps
`default_nettype none
`include "netfail_params.svh"

module process_data_watchdog_netfail #(
    parameter int unsigned MS_CYCLES = `MS_CYCLES,
    parameter int unsigned OUT_WIDTH = 8
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire netfail_pkg::req_type req,
    output netfail_pkg::resp_type     resp,
    input  wire logic                 web_manual_ack_mode,
    input  wire logic                 web_ack_strobe,
    input  wire logic [OUT_WIDTH-1:0] din_pin,
    input  wire logic [OUT_WIDTH-1:0] short_pin,
    output logic      [OUT_WIDTH-1:0] dout,
    output logic      [OUT_WIDTH-1:0] in_led,
    output logic      [OUT_WIDTH-1:0] out_led_yellow,
    output logic      [OUT_WIDTH-1:0] out_led_red,
    output logic                      net_led_green,
    output logic                      net_led_red
);

    localparam int TICK_W = $clog2(MS_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);
    // literal masks cannot be bit-selected, so they live in typed constants
    localparam logic [31:0] FC_OK_MASK = `FC_SUPPORTED;
    localparam logic [31:0] FC_WR_MASK = `FC_WRITING;

    // ==================================================
    // pin synchronisers
    logic [OUT_WIDTH-1:0] din_meta_reg, din_sync_reg;
    logic [OUT_WIDTH-1:0] short_meta_reg, short_sync_reg;

    // two stages each; only the second is read by logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_meta_reg   <= '0;
            din_sync_reg   <= '0;
            short_meta_reg <= '0;
            short_sync_reg <= '0;
        end else if (clk_en) begin
            din_meta_reg   <= din_pin;
            din_sync_reg   <= din_meta_reg;
            short_meta_reg <= short_pin;
            short_sync_reg <= short_meta_reg;
        end
    end

    // ==================================================
    // state
    logic [TICK_W-1:0]           tick_cnt_reg, tick_cnt_next;
    logic [15:0]                 wd_timeout_reg, wd_timeout_next;
    logic [15:0]                 wd_period_reg, wd_period_next;
    logic [15:0]                 wd_count_reg, wd_count_next;
    logic                        wd_run_reg, wd_run_next;
    logic [15:0]                 conn_timeout_reg, conn_timeout_next;
    logic [15:0]                 conn_period_reg, conn_period_next;
    logic [15:0]                 conn_count_reg, conn_count_next;
    logic                        conn_run_reg, conn_run_next;
    logic [15:0]                 mode_reg, mode_next;
    logic [15:0]                 reason_reg, reason_next;
    logic [15:0]                 out_image_reg, out_image_next;
    netfail_pkg::link_state_type link_reg, link_next;
    logic [OUT_WIDTH-1:0]        hold_reg, hold_next;
    logic [OUT_WIDTH-1:0]        dout_next;
    netfail_pkg::resp_type       resp_next;

    // ==================================================
    // decode helpers
    logic        tick, hit, ro, value_bad;
    logic [31:0] permit;
    logic [15:0] rd_value;
    logic [7:0]  exc;
    logic        accepted, wr, out_wr, cmd_set_fail, cmd_ack, ack_event;
    logic        wd_restart, wd_expire, conn_expire, fail_set;
    logic [15:0] status_value;
    logic [15:0] diag_value;
    logic [OUT_WIDTH-1:0] subst;

    // register map: which codes reach which register and what it reads
    always_comb begin
        hit      = 1'b1;
        ro       = 1'b0;
        permit   = 32'h0000_0000;
        rd_value = 16'h0000;
        value_bad = 1'b0;
        diag_value   = {15'h0000, |short_sync_reg};
        status_value = 16'h0000;
        status_value[`STAT_ERROR_BIT] = |diag_value;
        status_value[`STAT_FAIL_BIT]  = (link_reg == netfail_pkg::LINK_FAIL);
        case (req.addr)
            `OFS_CONN_TIMEOUT: begin
                permit    = `FC_SPECIAL_RW;
                rd_value  = conn_timeout_reg;
                value_bad = (req.wdata != 16'h0000) && ((req.wdata < `TIMEOUT_MIN_MS)
                            || (req.wdata > `TIMEOUT_MAX_MS));
            end
            `OFS_WD_TIMEOUT: begin
                permit    = `FC_SPECIAL_RW;
                rd_value  = wd_timeout_reg;
                value_bad = (req.wdata != 16'h0000) && ((req.wdata < `TIMEOUT_MIN_MS)
                            || (req.wdata > `TIMEOUT_MAX_MS));
            end
            `OFS_FAULT_MODE: begin
                permit    = `FC_SPECIAL_RW;
                rd_value  = mode_reg;
                value_bad = req.wdata > `MODE_HOLD_LAST;
            end
            `OFS_FAIL_REASON: begin
                permit   = `FC_READ_ONLY_REG;
                ro       = 1'b1;
                rd_value = reason_reg;
            end
            `OFS_COMMAND: begin
                permit    = `FC_COMMAND;
                value_bad = !$onehot(req.wdata) || !(req.wdata[`CMD_SET_FAIL_BIT]
                            || req.wdata[`CMD_ACK_BIT]);
            end
            `OFS_STATUS: begin
                permit   = `FC_READ_ONLY_REG;
                ro       = 1'b1;
                rd_value = status_value;
            end
            `OFS_DIAG_STATUS: begin
                permit   = `FC_READ_ONLY_REG;
                ro       = 1'b1;
                rd_value = diag_value;
            end
            `OFS_DIAG_PARAM: begin
                permit   = `FC_READ_ONLY_REG;
                ro       = 1'b1;
                rd_value = 16'(short_sync_reg);
            end
            `OFS_INPUT_IMAGE: begin
                permit   = `FC_INPUT_IMAGE;
                ro       = 1'b1;
                rd_value = 16'(din_sync_reg);
            end
            `OFS_OUTPUT_IMAGE: begin
                permit   = `FC_OUTPUT_IMAGE;
                rd_value = out_image_reg;
            end
            default: hit = 1'b0;
        endcase
    end

    // exception priority: unknown code, unknown register, read-only, code/register, value
    always_comb begin
        exc = `EXC_NONE;
        if (req.valid) begin
            if (!FC_OK_MASK[req.func]) begin
                exc = `EXC_ILLEGAL_FUNC;
            end else if (!hit) begin
                exc = `EXC_ILLEGAL_ADDR;
            end else if (req.write && ro) begin
                exc = `EXC_ILLEGAL_ADDR;
            end else if (!permit[req.func] || ((req.func != `FC_READ_WRITE)
                         && (req.write != FC_WR_MASK[req.func]))) begin
                exc = `EXC_ILLEGAL_FUNC;
            end else if (req.write && value_bad) begin
                exc = `EXC_ILLEGAL_VALUE;
            end
        end
    end

    // events derived from the accepted access; every connection is served alike
    assign accepted     = req.valid && (exc == `EXC_NONE);
    assign wr           = accepted && req.write;
    assign out_wr       = wr && (req.addr == `OFS_OUTPUT_IMAGE);
    assign cmd_set_fail = wr && (req.addr == `OFS_COMMAND) && req.wdata[`CMD_SET_FAIL_BIT];
    assign cmd_ack      = wr && (req.addr == `OFS_COMMAND) && req.wdata[`CMD_ACK_BIT];
    assign tick         = (tick_cnt_reg == TICK_LAST);
    // manual mode ignores image writes as acknowledgment; mode only from web side
    assign ack_event    = (link_reg == netfail_pkg::LINK_FAIL) && (cmd_ack || (web_manual_ack_mode
                          ? web_ack_strobe : out_wr));
    assign wd_restart   = (wd_timeout_reg != 16'h0000) && (ack_event
                          || (out_wr && link_reg == netfail_pkg::LINK_RUN));
    assign wd_expire    = wd_run_reg && tick && !wd_restart
                          && (wd_count_reg == wd_period_reg - 16'h0001);
    assign conn_expire  = conn_run_reg && tick && !accepted
                          && (conn_count_reg == conn_period_reg - 16'h0001);
    assign fail_set     = wd_expire || conn_expire || cmd_set_fail;
    assign subst        = (mode_reg == `MODE_ALL_LOW)  ? '0 :
                          (mode_reg == `MODE_ALL_HIGH) ? '1 : hold_reg;

    // ==================================================
    // next state of registers, watchdog, monitor and outputs
    always_comb begin
        tick_cnt_next     = tick ? '0 : tick_cnt_reg + TICK_W'(1);
        wd_timeout_next   = wd_timeout_reg;
        conn_timeout_next = conn_timeout_reg;
        mode_next         = mode_reg;
        out_image_next    = out_image_reg;
        wd_period_next    = wd_period_reg;
        wd_count_next     = wd_count_reg;
        wd_run_next       = wd_run_reg;
        conn_period_next  = conn_period_reg;
        conn_count_next   = conn_count_reg;
        conn_run_next     = conn_run_reg;
        link_next         = link_reg;
        reason_next       = reason_reg;
        hold_next         = hold_reg;
        // register writes; image writes are kept even during failure
        if (wr) begin
            case (req.addr)
                `OFS_CONN_TIMEOUT: conn_timeout_next = req.wdata;
                `OFS_WD_TIMEOUT:   wd_timeout_next   = req.wdata;
                `OFS_FAULT_MODE:   mode_next         = req.wdata;
                `OFS_OUTPUT_IMAGE: out_image_next    = (out_image_reg & ~req.wmask)
                                                       | (req.wdata & req.wmask);
                default:           mode_next         = mode_reg;
            endcase
        end
        // watchdog: only restart, expiry, the millisecond tick while running or a zero timeout touch it
        if (wd_restart) begin
            wd_run_next    = 1'b1;
            wd_count_next  = 16'h0000;
            wd_period_next = wd_timeout_reg;
        end else if (wd_expire) begin
            wd_run_next   = 1'b0;
            wd_count_next = 16'h0000;
        end else if (wd_run_reg && tick) begin
            wd_count_next = wd_count_reg + 16'h0001;
        end
        if (wr && req.addr == `OFS_WD_TIMEOUT && req.wdata == 16'h0000) begin
            wd_run_next = 1'b0;
        end
        // connection monitor: any executed function (re)starts it unless the timeout is zero
        if (accepted) begin
            conn_run_next    = (conn_timeout_reg != 16'h0000);
            conn_count_next  = 16'h0000;
            conn_period_next = conn_timeout_reg;
        end else if (conn_expire) begin
            conn_run_next   = 1'b0;
            conn_count_next = 16'h0000;
        end else if (conn_run_reg && tick) begin
            conn_count_next = conn_count_reg + 16'h0001;
        end
        // link failure; a new failure wins over an acknowledgment in the same cycle
        if (fail_set) begin
            link_next   = netfail_pkg::LINK_FAIL;
            reason_next = wd_expire ? `REASON_WATCHDOG :
                          conn_expire ? `REASON_CONN : `REASON_USER;
        end else if (ack_event) begin
            link_next = netfail_pkg::LINK_RUN;
        end
        // capture the driven outputs while healthy for the hold mode
        if (link_reg == netfail_pkg::LINK_RUN) begin
            hold_next = dout;
        end
        // outputs blocked during failure, latest image released afterwards
        dout_next = (link_reg == netfail_pkg::LINK_FAIL) ? subst
                    : out_image_reg[OUT_WIDTH-1:0];
        resp_next.valid     = req.valid;
        resp_next.exception = exc;
        resp_next.rdata     = (accepted && !req.write) ? rd_value : 16'h0000;
    end

    // register all state; clock enable freezes everything
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg     <= '0;
            wd_timeout_reg   <= `RST_TIMEOUT;
            wd_period_reg    <= `RST_TIMEOUT;
            wd_count_reg     <= 16'h0000;
            wd_run_reg       <= 1'b0;
            conn_timeout_reg <= `RST_TIMEOUT;
            conn_period_reg  <= `RST_TIMEOUT;
            conn_count_reg   <= 16'h0000;
            conn_run_reg     <= 1'b0;
            mode_reg         <= `RST_FAULT_MODE;
            reason_reg       <= `RST_REASON;
            out_image_reg    <= `RST_OUTPUT_IMAGE;
            link_reg         <= netfail_pkg::LINK_RUN;
            hold_reg         <= '0;
            dout             <= '0;
            resp             <= '0;
        end else if (clk_en) begin
            tick_cnt_reg     <= tick_cnt_next;
            wd_timeout_reg   <= wd_timeout_next;
            wd_period_reg    <= wd_period_next;
            wd_count_reg     <= wd_count_next;
            wd_run_reg       <= wd_run_next;
            conn_timeout_reg <= conn_timeout_next;
            conn_period_reg  <= conn_period_next;
            conn_count_reg   <= conn_count_next;
            conn_run_reg     <= conn_run_next;
            mode_reg         <= mode_next;
            reason_reg       <= reason_next;
            out_image_reg    <= out_image_next;
            link_reg         <= link_next;
            hold_reg         <= hold_next;
            dout             <= dout_next;
            resp             <= resp_next;
        end
    end

    // ==================================================
    // indicators, registered from the current state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_led         <= '0;
            out_led_yellow <= '0;
            out_led_red    <= '0;
            net_led_green  <= 1'b0;
            net_led_red    <= 1'b0;
        end else if (clk_en) begin
            in_led         <= din_sync_reg;
            out_led_yellow <= dout & ~short_sync_reg;
            out_led_red    <= short_sync_reg;
            net_led_red    <= (link_reg == netfail_pkg::LINK_FAIL);
            net_led_green  <= (link_reg == netfail_pkg::LINK_RUN);
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ack_release;
        clk_en && link_reg == netfail_pkg::LINK_FAIL && ack_event && !fail_set;
    endsequence

    sequence s_image_out;
        clk_en [*1] ##1 clk_en && dout == out_image_reg[OUT_WIDTH-1:0];
    endsequence

    chk_reset_idle: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rst_n |-> (wd_timeout_reg == 16'h0000) && !wd_run_reg)
        else $error("watchdog not idle in reset");
    chk_write_restart: assert property (
        clk_en && out_wr && wd_timeout_reg != 16'h0000 && link_reg == netfail_pkg::LINK_RUN
        |=> wd_run_reg && wd_count_reg == 16'h0000 && wd_period_reg == $past(wd_timeout_reg))
        else $error("output write did not restart watchdog");
    chk_read_no_start: assert property (
        clk_en && !wd_run_reg && req.valid && !req.write && !ack_event |=> !wd_run_reg)
        else $error("read started watchdog");
    chk_expire_fail: assert property (
        clk_en && wd_expire |=> link_reg == netfail_pkg::LINK_FAIL
        && reason_reg == `REASON_WATCHDOG ##1 clk_en [*1] ##0 status_value[`STAT_FAIL_BIT])
        else $error("expiry did not enter failure");
    chk_fail_holds: assert property (
        clk_en && link_reg == netfail_pkg::LINK_FAIL && !ack_event
        |=> link_reg == netfail_pkg::LINK_FAIL)
        else $error("failure left without acknowledgment");
    chk_zero_stops: assert property (
        clk_en && wr && req.addr == `OFS_WD_TIMEOUT && req.wdata == 16'h0000
        |=> !wd_run_reg && wd_timeout_reg == 16'h0000)
        else $error("zero timeout did not stop watchdog");
    chk_subst_low: assert property (
        clk_en && link_reg == netfail_pkg::LINK_FAIL && mode_reg == `MODE_ALL_LOW
        |=> dout == '0)
        else $error("mode zero outputs not low");
    chk_net_red: assert property (
        clk_en && link_reg == netfail_pkg::LINK_FAIL |=> net_led_red && !net_led_green)
        else $error("network lamp not red in failure");
    chk_ro_write_exc: assert property (
        clk_en && req.valid && req.write && req.addr == `OFS_INPUT_IMAGE
        && FC_OK_MASK[req.func] |=> resp.valid && resp.exception == `EXC_ILLEGAL_ADDR)
        else $error("read-only write not refused");
    chk_image_release: assert property (
        s_ack_release ##1 !(req.valid && req.write) |-> s_image_out)
        else $error("latest image not driven after release");

endmodule : process_data_watchdog_netfail
`default_nettype wire

// >>> test/client_model.sv
// behavioural client issuing one register access at a time
`timescale 1ns/100ps
`default_nettype none
module client_model (
    input  wire logic                  sys_clk,
    output netfail_pkg::req_type       req,
    input  wire netfail_pkg::resp_type resp
);
    // ==========
    // access: request held until the taking edge, answer read after it
    initial req = '0;
    task automatic access(input logic [4:0] fc, input logic [15:0] a, d,
                          output logic [7:0] exc, output logic [15:0] rd);
        @(posedge sys_clk);
        req <= '{1'b1, fc, fc inside {5, 6, 15, 16}, 3'h0, a, d, 16'hffff};
        @(posedge sys_clk);
        req.valid <= 1'b0;
        req.wdata <= ~d; // released data must not look stable
        #1;
        exc = resp.exception;
        rd  = resp.rdata;
    endtask : access
endmodule : client_model
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the watchdog and link-failure block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic sys_clk = 0, rst_n, mode = 0, web_ack = 0;
    logic [7:0] shrt = 0, dout, in_led, led_y, led_r, e;
    logic net_g, net_r;
    logic [15:0] r;
    netfail_pkg::req_type req;
    netfail_pkg::resp_type resp;
    int num_errors = 0, checked = 0, i;
    process_data_watchdog_netfail #(.MS_CYCLES(10)) dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_en(1'b1), .req(req), .resp(resp),
        .web_manual_ack_mode(mode), .web_ack_strobe(web_ack), .din_pin(8'h3c),
        .short_pin(shrt), .dout(dout), .in_led(in_led), .out_led_yellow(led_y),
        .out_led_red(led_r), .net_led_green(net_g), .net_led_red(net_r));
    client_model client (.sys_clk(sys_clk), .req(req), .resp(resp));
    // ==========
    // 40 ns clock
    initial forever #20 sys_clk = ~sys_clk;
    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    // one access with exception and read data judged
    task automatic acc(input logic [4:0] f, input logic [15:0] a, d, input logic [7:0] x,
                       input logic [15:0] xr);
        client.access(f, a, d, e, r);
        check(e, x);
        check(r, xr);
        check(resp.valid, 1'b1);
    endtask : acc
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // bounded wait for the red network lamp; running out ends the run
    task automatic wait_red(input int limit);
        for (i = 0; i < limit && net_r !== 1'b1; i++) @(posedge sys_clk);
        if (i == limit) begin
            num_errors++;
            finish_test;
        end
    endtask : wait_red
    // ==========
    // scenarios
    task automatic t_regs;
        acc(3, 16'h07d0, 0, 8'h00, 0);
        acc(6, 16'h1f40, 1, 8'h02, 0);
        acc(6, 16'h07d2, 3, 8'h03, 0);
        acc(6, 16'h07d0, 16'h0064, 8'h03, 0);
        acc(7, 16'h07d0, 0, 8'h01, 0);
        // input pins need their synchroniser delay before these hold
        acc(3, 16'h1f40, 0, 8'h00, 16'h003c);
        check(in_led, 8'h3c);
        $display("register test done");
    endtask : t_regs
    task automatic t_expire;
        acc(6, 16'h07d0, 16'h00c8, 0, 0);
        acc(6, 16'h07d2, 1, 0, 0);
        acc(16, 16'h2328, 16'h00a5, 0, 0);
        // reads alone must let the 200 ms period run out
        for (i = 0; i < 990; i++) acc(3, 16'h2328, 0, 0, 16'h00a5);
        check(net_r, 0);
        wait_red(40);
        check(net_r, 1);
        check(dout, 8'hff);
        acc(3, 16'h1f3c, 0, 0, 16'h0002);
        acc(6, 16'h2328, 16'h003c, 0, 0);
        repeat (2) @(posedge sys_clk);
        #1 check(dout, 8'h3c);
        check(net_g, 1);
        acc(6, 16'h07d0, 0, 0, 0);
        $display("expiry test done");
    endtask : t_expire
    task automatic t_manual;
        @(posedge sys_clk);
        mode <= 1'b1;
        acc(6, 16'h07d6, 16'h0010, 0, 0);
        acc(6, 16'h2328, 16'h0055, 0, 0);
        repeat (3) @(posedge sys_clk);
        #1 check(dout, 8'hff);
        acc(6, 16'h07d6, 16'h0030, 8'h03, 0);
        acc(6, 16'h07d6, 16'h0020, 0, 0);
        @(posedge sys_clk);
        shrt <= 8'h01;
        repeat (5) @(posedge sys_clk);
        #1 check(dout, 8'h55);
        check(led_r, 8'h01);
        check(led_y, 8'h54);
        $display("manual test done");
    endtask : t_manual
    // hold-last substitutes, web acknowledgment, connection monitor expiry
    task automatic t_hold;
        acc(6, 16'h07d2, 2, 0, 0);
        acc(6, 16'h07d6, 16'h0010, 0, 0);
        acc(3, 16'h07d4, 0, 0, 16'h0009);
        acc(6, 16'h2328, 16'h000f, 0, 0);
        repeat (2) @(posedge sys_clk);
        #1 check(dout, 8'h55);
        @(posedge sys_clk);
        web_ack <= 1'b1;
        @(posedge sys_clk);
        web_ack <= 1'b0;
        mode    <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check(dout, 8'h0f);
        // the monitor only starts with the access after the timeout write
        acc(6, 16'h0500, 16'h00c8, 0, 0);
        acc(6, 16'h07d2, 0, 0, 0);
        wait_red(2100);
        #1 check(dout, 8'h00);
        acc(3, 16'h07d4, 0, 0, 16'h000d);
        acc(3, 16'h1f3c, 0, 0, 16'h0003);
        acc(6, 16'h2328, 16'h00f0, 0, 0);
        repeat (2) @(posedge sys_clk);
        #1 check(dout, 8'hf0);
        check(net_g, 1);
        $display("hold and web test done");
    endtask : t_hold
    // main sequence
    initial begin
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs;
        t_expire;
        t_manual;
        t_hold;
        finish_test;
    end
endmodule : testbench
`default_nettype wire
